// File: lar_host.sv
// lar_host: host controller model giving start pulses and stream ready
// assumes bench commands change just after a rising clk_sys edge
`timescale 1ns/10ps
module lar_host
(
  // clock and bench commands
  input wire logic clk_sys,
  input wire logic go,
  input wire logic par,
  input wire logic stall,
  // device side
  input wire logic section1_token_out,
  output logic section1_start_in,
  output logic section2_start_in,
  output logic pix_out_ready
);
  logic s1_reg = 1'b0;
  logic s2_reg = 1'b0;
  // one-clock start pulse, both sections together in parallel mode
  always @(posedge clk_sys)
  begin
    s1_reg <= go;
    s2_reg <= go & par;
  end
  // serial chain feeds token 1 into section 2 start
  assign section1_start_in = s1_reg;
  assign section2_start_in = par ? s2_reg : section1_token_out;
  assign pix_out_ready = !stall;
endmodule // lar_host

// File: lar_pkg.sv
// lar_pkg: constants shared by the linear array readout sequencer files
// assumes nothing beyond a SystemVerilog package-aware compiler
package lar_pkg;
  localparam int SECTION_PIXELS = 128;
  localparam int ARRAY_PIXELS = 256;
  localparam int SECTIONS = 2;
  localparam int PIX_W = 8;
  localparam int ARR_IDX_W = 8;
  localparam int SEC_IDX_W = 7;
  localparam int CYC_W = 9;
  // integrators held in reset for this many clocks of an output cycle
  localparam logic [8:0] RESET_CLOCKS = 9'h012;
  localparam logic [8:0] CYC_MAX = 9'h1ff;
  localparam logic [7:0] PIX_MAX = 8'hff;
  localparam logic [7:0] PIX_ZERO = 8'h00;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = 2 * PIX_W + 2 + SEC_IDX_W;
endpackage

// File: lar_readout.sv
// lar_readout: hold, integrator reset and pixel readout sequencer of a 256-pixel line sensor
// assumes all inputs synchronous to clk_sys; analog levels are modelled as pixel codes
`timescale 1ns/10ps
module lar_readout
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // section starts
  input wire logic section1_start_in,
  input wire logic section2_start_in,
  // light level per pixel, the integrators' input
  input wire logic light_wr_en,
  input wire logic [lar_pkg::ARR_IDX_W-1:0] light_wr_index,
  input wire logic [lar_pkg::PIX_W-1:0] light_wr_data,
  // section outputs, enable high while driven
  output logic [lar_pkg::PIX_W-1:0] section1_analog_out,
  output logic section1_analog_oe,
  output logic [lar_pkg::PIX_W-1:0] section2_analog_out,
  output logic section2_analog_oe,
  // token outputs
  output logic section1_token_out,
  output logic section2_token_out,
  // sequencing state
  output logic hold_out,
  output logic integ_reset_out,
  // buffered pixel stream
  output logic pix_out_valid,
  input wire logic pix_out_ready,
  output logic [2*lar_pkg::PIX_W-1:0] pix_out_data,
  output logic [1:0] pix_out_lane,
  output logic [lar_pkg::SEC_IDX_W-1:0] pix_out_index
);
  logic [lar_pkg::PIX_W-1:0] light_reg [lar_pkg::ARRAY_PIXELS];
  logic [lar_pkg::PIX_W-1:0] integ_reg [lar_pkg::ARRAY_PIXELS];
  logic [lar_pkg::PIX_W-1:0] sample_reg [lar_pkg::ARRAY_PIXELS];
  logic si1_q_reg;
  logic start1;
  logic start2;
  logic hold_reg;
  logic [lar_pkg::CYC_W-1:0] cyc_reg;
  logic integ_rst;
  logic [1:0] tok_out;
  logic [1:0] sec_active;
  logic [lar_pkg::SEC_IDX_W-1:0] sec_index [2];
  logic advance;
  logic in_valid;
  logic in_ready;
  logic [lar_pkg::BUF_W-1:0] in_word;
  logic [lar_pkg::BUF_W-1:0] buf_reg [lar_pkg::BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;
  logic [lar_pkg::BUF_W-1:0] out_word;

  // start edge detect on section 1
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      si1_q_reg <= 1'b0;
    else
      si1_q_reg <= section1_start_in;
  end

  assign start1 = section1_start_in && !si1_q_reg;
  assign start2 = section2_start_in;

  // hold flag: raised on start, dropped when no section is reading
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      hold_reg <= 1'b0;
    else if (start1)
      hold_reg <= 1'b1;
    else if (!(|sec_active) && !start2)
      hold_reg <= 1'b0;
  end

  // clock count of the output cycle, saturating
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cyc_reg <= lar_pkg::CYC_MAX;
    else if (start1)
      cyc_reg <= 9'h001;
    else if (cyc_reg != lar_pkg::CYC_MAX)
      cyc_reg <= cyc_reg + 9'h001;
  end

  // start clock and clocks 1 to 17 keep integrators cleared
  assign integ_rst = start1 || (cyc_reg < lar_pkg::RESET_CLOCKS);

  // light level table
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < lar_pkg::ARRAY_PIXELS; i++)
        light_reg[i] <= lar_pkg::PIX_ZERO;
    else if (light_wr_en)
      light_reg[light_wr_index] <= light_wr_data;
  end

  // integrators, saturating, one per pixel of the contiguous line
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < lar_pkg::ARRAY_PIXELS; i++)
        integ_reg[i] <= lar_pkg::PIX_ZERO;
    else
      for (int i = 0; i < lar_pkg::ARRAY_PIXELS; i++)
        if (integ_rst)
          integ_reg[i] <= lar_pkg::PIX_ZERO;
        else if ({1'b0, integ_reg[i]} + {1'b0, light_reg[i]} > {1'b0, lar_pkg::PIX_MAX})
          integ_reg[i] <= lar_pkg::PIX_MAX;
        else
          integ_reg[i] <= integ_reg[i] + light_reg[i];
  end

  // all sampling capacitors disconnect at once on the hold
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < lar_pkg::ARRAY_PIXELS; i++)
        sample_reg[i] <= lar_pkg::PIX_ZERO;
    else if (start1)
      for (int i = 0; i < lar_pkg::ARRAY_PIXELS; i++)
        sample_reg[i] <= integ_reg[i];
  end

  // token stalls only while a full buffer refuses the pixel
  assign advance = !(|sec_active) || in_ready;

  // two 128-stage sections; only serial wiring outside chains them into 256 stages
  lar_section u_sec1
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start_in(start1),
    .advance(advance),
    .token_out(tok_out[0]),
    .active(sec_active[0]),
    .index(sec_index[0])
  );

  lar_section u_sec2
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start_in(start2),
    .advance(advance),
    .token_out(tok_out[1]),
    .active(sec_active[1]),
    .index(sec_index[1])
  );

  // token outputs; serial wiring feeds section 1 token to section 2 start
  assign section1_token_out = tok_out[0];
  assign section2_token_out = tok_out[1];

  // held pixel routed to its section output while its token is active
  assign section1_analog_out = sample_reg[{1'b0, sec_index[0]}];
  assign section2_analog_out = sample_reg[{1'b1, sec_index[1]}];
  assign section1_analog_oe = sec_active[0];
  assign section2_analog_oe = sec_active[1];

  // sequencing state to the pins
  assign hold_out = hold_reg;
  assign integ_reset_out = integ_rst;

  // pixel word for the stream: both lanes, lane flags, index
  assign in_valid = |sec_active;
  assign in_word = {section2_analog_out, section1_analog_out, sec_active,
                    sec_active[0] ? sec_index[0] : sec_index[1]};

  // two-entry buffer
  assign in_ready = (count_reg != 2'h2);
  assign push = in_valid && in_ready;
  assign pop = pix_out_valid && pix_out_ready;

  // write side: store the pixel word, step the write pointer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= 1'b0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
    end
    else if (push)
    begin
      buf_reg[wr_ptr_reg] <= in_word;
      wr_ptr_reg <= !wr_ptr_reg;
    end
  end

  // read side: step the read pointer on each pop
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rd_ptr_reg <= 1'b0;
    else if (pop)
      rd_ptr_reg <= !rd_ptr_reg;
  end

  // fill level, unchanged when push and pop meet
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= 2'h0;
    else if (push && !pop)
      count_reg <= count_reg + 2'h1;
    else if (pop && !push)
      count_reg <= count_reg - 2'h1;
  end

  // stream outputs straight from buffer flops
  assign out_word = buf_reg[rd_ptr_reg];
  assign pix_out_valid = (count_reg != 2'h0);
  assign pix_out_data = out_word[lar_pkg::BUF_W-1 -: 2*lar_pkg::PIX_W];
  assign pix_out_lane = out_word[lar_pkg::SEC_IDX_W +: 2];
  assign pix_out_index = out_word[lar_pkg::SEC_IDX_W-1:0];
endmodule // lar_readout

// File: lar_readout_properties.sv
// lar_checker: timing relations at the ports of the readout sequencer
// assumes one clk_sys domain, rst_n async active low, host keeps ready high except in stalls
`timescale 1ns/10ps
module lar_checker
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // starts and tokens
  input wire logic section1_start_in,
  input wire logic section2_start_in,
  input wire logic section1_token_out,
  input wire logic section2_token_out,
  // outputs and sequencing
  input wire logic section1_analog_oe,
  input wire logic section2_analog_oe,
  input wire logic hold_out,
  input wire logic integ_reset_out,
  // stream
  input wire logic pix_out_valid,
  input wire logic pix_out_ready,
  input wire logic [2*lar_pkg::PIX_W-1:0] pix_out_data
);
  logic stall_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // any stall stretches token timing from then on
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      stall_reg <= 1'b0;
    else if (!pix_out_ready)
      stall_reg <= 1'b1;
  end
  start_hold_a: assert property ($rose(section1_start_in) |=> hold_out && section1_analog_oe)
    else $error("hold or output 1 missing after start");
  reset_span_a: assert property ($rose(section1_start_in) |-> ##17 integ_reset_out ##1 !integ_reset_out)
    else $error("integrator reset span wrong");
  token1_time_a: assert property (disable iff (!rst_n || stall_reg)
    $rose(section1_start_in) |-> ##128 section1_token_out) else $error("token 1 late");
  token1_end_a: assert property (disable iff (!rst_n || stall_reg)
    $rose(section1_token_out) |=> !section1_token_out && !section1_analog_oe) else $error("token 1 end wrong");
  sect2_on_a: assert property (disable iff (!rst_n || stall_reg)
    section1_token_out && section2_start_in |=> section2_analog_oe) else $error("output 2 not active");
  token2_time_a: assert property (disable iff (!rst_n || stall_reg)
    $rose(section2_start_in) |-> ##128 section2_token_out) else $error("token 2 late");
  token2_end_a: assert property (disable iff (!rst_n || stall_reg)
    $rose(section2_token_out) |=> !section2_token_out && !section2_analog_oe) else $error("token 2 end wrong");
  idle_float_a: assert property (!hold_out |-> !section1_analog_oe && !section2_analog_oe)
    else $error("output driven outside readout");
  stream_hold_a: assert property (pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out_data))
    else $error("stalled word lost");
  cover property ($rose(section1_start_in));
  cover property ($rose(section2_token_out));
  cover property (section1_token_out && section2_start_in);
  cover property (pix_out_valid && !pix_out_ready);
endmodule // lar_checker
bind lar_readout lar_checker lar_checker_i (.clk_sys, .rst_n, .section1_start_in, .section2_start_in,
  .section1_token_out, .section2_token_out, .section1_analog_oe, .section2_analog_oe, .hold_out,
  .integ_reset_out, .pix_out_valid, .pix_out_ready, .pix_out_data);

// File: lar_readout_tb_top.sv
// lar_readout_tb_top: serial, parallel and stalled readouts of the sequencer
// assumes the lar_host model drives starts and ready
`timescale 1ns/10ps
module lar_readout_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic par = 1'b0;
  logic stall = 1'b0;
  logic light_wr_en = 1'b0;
  logic [7:0] light_wr_index = 8'h00;
  logic [7:0] light_wr_data = 8'h00;
  logic section1_start_in, section2_start_in, pix_out_ready, section1_analog_oe, section2_analog_oe;
  logic section1_token_out, section2_token_out, hold_out, integ_reset_out, pix_out_valid;
  logic [7:0] section1_analog_out, section2_analog_out;
  logic [15:0] pix_out_data;
  logic [1:0] pix_out_lane;
  logic [6:0] pix_out_index;
  int fails = 0;
  int checks = 0;
  // 100 ns clock
  always #50 clk_sys = ~clk_sys;
  lar_host lar_host_i (.clk_sys, .go, .par, .stall, .section1_token_out, .section1_start_in,
    .section2_start_in, .pix_out_ready);
  lar_readout lar_readout_i (.clk_sys, .rst_n, .section1_start_in, .section2_start_in, .light_wr_en,
    .light_wr_index, .light_wr_data, .section1_analog_out, .section1_analog_oe, .section2_analog_out,
    .section2_analog_oe, .section1_token_out, .section2_token_out, .hold_out, .integ_reset_out,
    .pix_out_valid, .pix_out_ready, .pix_out_data, .pix_out_lane, .pix_out_index);
  function automatic logic [7:0] lvl(input int n);
    return {8{n[0] ^ n[7]}};
  endfunction
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic load_light;
    for (int n = 0; n < 256; n++)
    begin
      @(posedge clk_sys);
      light_wr_en <= 1'b1;
      light_wr_index <= n[7:0];
      light_wr_data <= lvl(n);
    end
    @(posedge clk_sys);
    light_wr_en <= 1'b0;
  endtask
  task automatic kick(input logic p);
    @(posedge clk_sys);
    par <= p;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic serial_readout;
    kick(1'b0);
    for (int n = 0; n < 256; n++)
    begin
      cmp("hold", 1'b1, hold_out);
      cmp("oe", {n >= 128, n < 128}, {section2_analog_oe, section1_analog_oe});
      cmp("code", lvl(n), n < 128 ? section1_analog_out : section2_analog_out);
      cmp("tok", {n == 255, n == 127}, {section2_token_out, section1_token_out});
      cmp("ireset", n < 17, integ_reset_out);
      @(posedge clk_sys);
      #1;
    end
    cmp("end", 3'b000, {section2_token_out, section2_analog_oe, section1_analog_oe});
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic parallel_readout;
    kick(1'b1);
    for (int n = 0; n < 128; n++)
    begin
      cmp("oe", 2'b11, {section2_analog_oe, section1_analog_oe});
      cmp("codes", {lvl(n + 128), lvl(n)}, {section2_analog_out, section1_analog_out});
      cmp("tok", {2{n == 127}}, {section2_token_out, section1_token_out});
      @(posedge clk_sys);
      #1;
    end
    cmp("oe", 2'b00, {section2_analog_oe, section1_analog_oe});
    cmp("tok", 2'b00, {section2_token_out, section1_token_out});
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic stalled_stream;
    int got;
    got = 0;
    @(posedge clk_sys);
    stall <= 1'b1;
    kick(1'b1);
    repeat (20) @(posedge clk_sys);
    #1;
    cmp("valid", 2'b11, {pix_out_valid, section1_analog_oe});
    @(posedge clk_sys);
    stall <= 1'b0;
    for (int k = 0; k < 400 && got < 128; k++)
    begin
      @(negedge clk_sys);
      if (pix_out_valid === 1'b1 && pix_out_ready === 1'b1)
      begin
        cmp("word", {lvl(got + 128), lvl(got)}, pix_out_data);
        cmp("index", {2'b11, got[6:0]}, {pix_out_lane, pix_out_index});
        got++;
      end
    end
    cmp("words", 16'h0080, got[15:0]);
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    load_light;
    serial_readout;
    parallel_readout;
    stalled_stream;
    stop_test;
  end
  // watchdog against a hang
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    fails++;
    stop_test;
  end
endmodule // lar_readout_tb_top

// File: lar_section.sv
// lar_section: one 128-stage token shifter of the readout chain
// assumes start_in is synchronous to clk_sys and high for one clock
`timescale 1ns/10ps
module lar_section
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // token control
  input wire logic start_in,
  input wire logic advance,
  // token state
  output logic token_out,
  output logic active,
  output logic [lar_pkg::SEC_IDX_W-1:0] index
);
  logic [lar_pkg::SECTION_PIXELS-1:0] tok_reg;
  logic [lar_pkg::SEC_IDX_W-1:0] idx_reg;

  // token moves one stage per clock unless the stream stalls
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tok_reg <= '0;
    else if (advance)
      tok_reg <= {tok_reg[lar_pkg::SECTION_PIXELS-2:0], start_in};
    else
      tok_reg <= tok_reg | {{(lar_pkg::SECTION_PIXELS-1){1'b0}}, start_in};
  end

  // pixel index tracks the token position
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      idx_reg <= '0;
    else if (start_in)
      idx_reg <= '0;
    else if (advance && active)
      idx_reg <= idx_reg + 7'h01;
  end

  assign active = |tok_reg;
  assign token_out = tok_reg[lar_pkg::SECTION_PIXELS-1];
  assign index = idx_reg;
endmodule // lar_section
